// File: include/tcc_pkg.sv
// constants and types for the timer capture/compare channel block
package tcc_pkg;
	localparam int         CNT_W         = 16;
	localparam int         ADDR_W        = 8;
	localparam int         SYNC_STAGES   = 3;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_COUNT     = 8'h04;
	localparam logic [7:0] OFS_CH_BASE   = 8'h10;
	localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
	localparam logic [7:0] OFS_CCR_DELTA = 8'h04;
	// control register fields
	localparam int         CTL_MODE_LSB  = 0;
	localparam int         CTL_CLR       = 2;
	localparam int         CTL_WRAP_IE   = 3;
	localparam int         CTL_WRAP_FLAG = 4;
	localparam int         CTL_GIE       = 5;
	// channel control register fields
	localparam int         CC_FLAG       = 0;
	localparam int         CC_OVR        = 1;
	localparam int         CC_OUT        = 2;
	localparam int         CC_LVL        = 3;
	localparam int         CC_SLVL       = 4;
	localparam int         CC_OMODE_LSB  = 5;
	localparam int         CC_IE         = 8;
	localparam int         CC_SYNC       = 11;
	localparam int         CC_CAP        = 12;
	localparam int         CC_ISEL_LSB   = 13;
	localparam int         CC_EDGE_LSB   = 15;
	// reset values
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic [15:0] CCR_RST      = 16'h0000;
	localparam logic [31:0] RDATA_NONE   = 32'h0000_0000;
	// capture input select codes
	localparam logic [1:0] ISEL_A        = 2'h0;
	localparam logic [1:0] ISEL_B        = 2'h1;
	localparam logic [1:0] ISEL_GND      = 2'h2;
	localparam logic [1:0] ISEL_VCC      = 2'h3;
	typedef enum logic [1:0]
	{
		CM_STOP = 2'b00,
		CM_UP   = 2'b01,
		CM_CONT = 2'b10,
		CM_UPDN = 2'b11
	} tcc_cnt_mode_t;
	typedef enum logic [2:0]
	{
		OM_OUT     = 3'b000,
		OM_SET     = 3'b001,
		OM_TOG_RST = 3'b010,
		OM_SET_RST = 3'b011,
		OM_TOG     = 3'b100,
		OM_RST     = 3'b101,
		OM_TOG_SET = 3'b110,
		OM_RST_SET = 3'b111
	} tcc_out_mode_t;
endpackage

// File: rtl/tcc_capture.sv
// capture input synchroniser, source select and edge detector
`timescale 1ns/10ps
module tcc_capture
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       capInA,
	input  wire logic       capInB,
	input  wire logic [1:0] inSel,
	input  wire logic [1:0] edgeSel,
	input  wire logic       syncSel,
	input  wire logic       capEnable,
	output logic            level,
	output logic            capPulse
);
	import tcc_pkg::*;

	logic [SYNC_STAGES-1:0] syncA_r;
	logic [SYNC_STAGES-1:0] syncB_r;
	logic                   fltA_r;
	logic                   fltB_r;
	logic                   prev_r;
	logic                   capDly_r;
	logic                   capRaw;

	////////////////////////////////////////////////////////////////////////
	// pins are asynchronous: three stages, level moves once last two agree
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syncA_r <= '0;
			syncB_r <= '0;
			fltA_r  <= 1'b0;
			fltB_r  <= 1'b0;
		end
		else
		begin
			syncA_r <= {syncA_r[SYNC_STAGES-2:0], capInA};
			syncB_r <= {syncB_r[SYNC_STAGES-2:0], capInB};
			if (syncA_r[1] == syncA_r[2])
				fltA_r <= syncA_r[2];
			if (syncB_r[1] == syncB_r[2])
				fltB_r <= syncB_r[2];
		end
	end

	// supply codes let software force an edge by flipping the low bit
	always_comb
	begin
		case (inSel)
			ISEL_A:   level = fltA_r;
			ISEL_B:   level = fltB_r;
			ISEL_GND: level = 1'b0;
			ISEL_VCC: level = 1'b1;
			default:  level = 1'b0;
		endcase
	end

	assign capRaw = capEnable & ((edgeSel[0] & level & ~prev_r) |
		(edgeSel[1] & ~level & prev_r));

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prev_r   <= 1'b0;
			capDly_r <= 1'b0;
		end
		else
		begin
			prev_r   <= level;
			capDly_r <= capRaw;
		end
	end

	// resync costs one cycle of capture latency
	assign capPulse = syncSel ? capDly_r : capRaw;

	////////////////////////////////////////////////////////////////////////
	chk_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
		(syncSel && capRaw) ##1 syncSel |-> capPulse)
		else $error("synchronised capture not issued one cycle later");
	chk_edge_cause: assert property (@(posedge clk) disable iff (sys_rst)
		(capPulse && !syncSel) |-> (level != prev_r) &&
		(level ? edgeSel[0] : edgeSel[1]))
		else $error("capture without the selected edge");
endmodule

// File: rtl/tcc_output_unit.sv
// per-channel output unit with eight output modes
`timescale 1ns/10ps
module tcc_output_unit
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire tcc_pkg::tcc_out_mode_t outMode,
	input  wire logic                   chMatch,
	input  wire logic                   perMatch,
	input  wire logic                   swBit,
	input  wire logic                   timerClr,
	output logic                        outLevel
);
	import tcc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// period match wins where both fire in one cycle in modes 2, 3, 6 and 7
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			outLevel <= 1'b0;
		else
		begin
			case (outMode)
				OM_OUT:
					outLevel <= swBit;
				OM_SET:
					if (timerClr)
						outLevel <= 1'b0;
					else if (chMatch)
						outLevel <= 1'b1;
				OM_TOG_RST:
					if (perMatch)
						outLevel <= 1'b0;
					else if (chMatch)
						outLevel <= ~outLevel;
				OM_SET_RST:
					if (perMatch)
						outLevel <= 1'b0;
					else if (chMatch)
						outLevel <= 1'b1;
				OM_TOG:
					if (chMatch)
						outLevel <= ~outLevel;
				OM_RST:
					if (chMatch)
						outLevel <= 1'b0;
				OM_TOG_SET:
					if (perMatch)
						outLevel <= 1'b1;
					else if (chMatch)
						outLevel <= ~outLevel;
				OM_RST_SET:
					if (perMatch)
						outLevel <= 1'b1;
					else if (chMatch)
						outLevel <= 1'b0;
				default:
					outLevel <= outLevel;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_mode0_follow: assert property (@(posedge clk) disable iff (sys_rst)
		outMode == OM_OUT |=> outLevel == $past(swBit))
		else $error("mode 0 output does not follow software bit");
	chk_toggle_mode: assert property (@(posedge clk) disable iff (sys_rst)
		(outMode == OM_TOG && chMatch) |=> outLevel != $past(outLevel))
		else $error("toggle mode did not toggle on match");
	chk_period_reset: assert property (@(posedge clk) disable iff (sys_rst)
		(outMode == OM_SET_RST && perMatch) |=> !outLevel)
		else $error("set/reset mode not reset by period match");
	chk_period_set: assert property (@(posedge clk) disable iff (sys_rst)
		(outMode == OM_RST_SET && perMatch) |=> outLevel)
		else $error("reset/set mode not set by period match");
endmodule

// File: rtl/tcc_top.sv
// timer counter with capture/compare channels behind an avalon-mm slave
`timescale 1ns/10ps
module tcc_top
#(
	parameter int NCH = 3
)
(
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic [tcc_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest,
	input  wire logic [NCH-1:0]            capInA,
	input  wire logic [NCH-1:0]            capInB,
	output logic [NCH-1:0]                 chanOut,
	output logic                           irqCh0,
	output logic                           irqShared
);
	import tcc_pkg::*;

	function automatic logic [31:0] mergeBe(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			mergeBe[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
	endfunction

	function automatic logic isChReg(input logic [7:0] addr, input int idx,
		input logic ccr);
		isChReg = addr == 8'(OFS_CH_BASE + 8'(idx) * OFS_CH_STRIDE +
			(ccr ? OFS_CCR_DELTA : 8'h00));
	endfunction

	tcc_cnt_mode_t    cntMode_r;
	logic             wrapIe_r;
	logic             wrapFlag_r;
	logic             gie_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] countNxt;
	logic             dirDown_r;
	logic             dirDownNxt;
	logic             wrapSet;
	logic             adv_r;
	logic [CNT_W-1:0] periodLatch_r;
	logic [CNT_W-1:0] ccr_r [NCH];
	tcc_out_mode_t    outMode_r [NCH];
	logic [1:0]       inSel_r [NCH];
	logic [1:0]       edgeSel_r [NCH];
	logic [31:0]      ctlView [NCH];
	logic [NCH-1:0]   flag_r;
	logic [NCH-1:0]   ovr_r;
	logic [NCH-1:0]   unread_r;
	logic [NCH-1:0]   outBit_r;
	logic [NCH-1:0]   outBitNxt;
	logic [NCH-1:0]   ie_r;
	logic [NCH-1:0]   syncSel_r;
	logic [NCH-1:0]   capMode_r;
	logic [NCH-1:0]   sLevel_r;
	logic [NCH-1:0]   level;
	logic [NCH-1:0]   capEvt;
	logic [NCH-1:0]   chMatch;
	logic             perMatch;
	logic             waitReq_r;
	logic [31:0]      readData_r;
	logic [31:0]      rdMux;
	logic             accRd;
	logic             accWr;
	logic             wrCtrl;
	logic             wrCount;
	logic             timerClr;
	logic [31:0]      ctrlView;
	logic [31:0]      ctrlNew;
	logic [31:0]      countNew;
	logic [31:0]      perNew;
	logic             irqCh0_r;
	logic             irqShared_r;

	////////////////////////////////////////////////////////////////////////
	// one wait state per access; effects land on the edge that completes it
	assign accRd = avs_read & ~waitReq_r;
	assign accWr = avs_write & ~waitReq_r;
	assign avs_waitrequest = waitReq_r;
	assign avs_readdata = readData_r;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			waitReq_r <= 1'b1;
		else
			waitReq_r <= ~((avs_read | avs_write) & waitReq_r);
	end

	always_comb
	begin
		rdMux = RDATA_NONE;
		if (avs_address == OFS_CTRL)
			rdMux = ctrlView;
		else if (avs_address == OFS_COUNT)
			rdMux = {16'h0000, count_r};
		for (int i = 0; i < NCH; i++)
		begin
			if (isChReg(avs_address, i, 1'b0))
				rdMux = ctlView[i];
			if (isChReg(avs_address, i, 1'b1))
				rdMux = {16'h0000, ccr_r[i]};
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			readData_r <= RDATA_NONE;
		else if (avs_read & waitReq_r)
			readData_r <= rdMux;
	end

	////////////////////////////////////////////////////////////////////////
	// global control; the clear bit is a strobe and reads back as zero
	assign ctrlView = {26'h0, gie_r, wrapFlag_r, wrapIe_r, 1'b0, cntMode_r};
	assign ctrlNew  = mergeBe(ctrlView, avs_writedata, avs_byteenable);
	assign countNew = mergeBe({16'h0000, count_r}, avs_writedata,
		avs_byteenable);
	assign wrCtrl   = accWr & (avs_address == OFS_CTRL);
	assign wrCount  = accWr & (avs_address == OFS_COUNT);
	assign timerClr = wrCtrl & ctrlNew[CTL_CLR];

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cntMode_r <= CM_STOP;
			wrapIe_r  <= 1'b0;
			gie_r     <= 1'b0;
		end
		else if (wrCtrl)
		begin
			cntMode_r <= tcc_cnt_mode_t'(ctrlNew[CTL_MODE_LSB +: 2]);
			wrapIe_r  <= ctrlNew[CTL_WRAP_IE];
			gie_r     <= ctrlNew[CTL_GIE];
		end
	end

	// a wrap in the same cycle as a software clear does not set the flag
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			wrapFlag_r <= 1'b0;
		else
			wrapFlag_r <= (wrapSet & ~wrCount & ~timerClr) |
				(wrCtrl ? ctrlNew[CTL_WRAP_FLAG] : wrapFlag_r);
	end

	////////////////////////////////////////////////////////////////////////
	// counter; a zero period halts up and up/down counting
	always_comb
	begin
		countNxt   = count_r;
		dirDownNxt = dirDown_r;
		wrapSet    = 1'b0;
		case (cntMode_r)
			CM_UP:
				if (periodLatch_r != '0)
				begin
					if (count_r >= periodLatch_r)
					begin
						countNxt = '0;
						wrapSet  = 1'b1;
					end
					else
						countNxt = count_r + 16'h0001;
				end
			CM_CONT:
			begin
				countNxt = count_r + 16'h0001;
				wrapSet  = &count_r;
			end
			CM_UPDN:
				if (periodLatch_r != '0)
				begin
					if (dirDown_r)
					begin
						// descent ignores the period until zero
						if (count_r == '0)
						begin
							countNxt   = 16'h0001;
							dirDownNxt = 1'b0;
						end
						else
						begin
							countNxt = count_r - 16'h0001;
							if (count_r == 16'h0001)
							begin
								wrapSet    = 1'b1;
								dirDownNxt = 1'b0;
							end
						end
					end
					else if (count_r >= periodLatch_r)
					begin
						countNxt   = count_r - 16'h0001;
						dirDownNxt = 1'b1;
					end
					else
						countNxt = count_r + 16'h0001;
				end
			default:
				countNxt = count_r;
		endcase
	end

	// a software load never marks an advance, so it cannot match
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count_r   <= COUNT_RST;
			dirDown_r <= 1'b0;
			adv_r     <= 1'b0;
		end
		else if (timerClr)
		begin
			count_r   <= COUNT_RST;
			dirDown_r <= 1'b0;
			adv_r     <= 1'b0;
		end
		else if (wrCount)
		begin
			count_r <= countNew[CNT_W-1:0];
			adv_r   <= 1'b0;
		end
		else
		begin
			count_r   <= countNxt;
			dirDown_r <= dirDownNxt;
			adv_r     <= countNxt != count_r;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			periodLatch_r <= CCR_RST;
		else if (accWr && isChReg(avs_address, 0, 1'b1))
			periodLatch_r <= perNew[CNT_W-1:0];
	end

	assign perNew = mergeBe({16'h0000, ccr_r[0]}, avs_writedata,
		avs_byteenable);

	assign perMatch = adv_r & (count_r == ccr_r[0]);

	////////////////////////////////////////////////////////////////////////
	// channels
	generate
		for (genvar i = 0; i < NCH; i++)
		begin : g_ch
			logic [31:0] ctlNew;
			logic [31:0] ccrNew;
			logic        wrCtl;
			logic        wrCcr;
			logic        rdCcr;

			assign ctlView[i] = {15'h0000, edgeSel_r[i], inSel_r[i],
				capMode_r[i], syncSel_r[i], 2'b00, ie_r[i], outMode_r[i],
				sLevel_r[i], level[i], outBit_r[i], ovr_r[i], flag_r[i]};
			assign ctlNew = mergeBe(ctlView[i], avs_writedata, avs_byteenable);
			assign ccrNew = mergeBe({16'h0000, ccr_r[i]}, avs_writedata,
				avs_byteenable);
			assign wrCtl  = accWr & isChReg(avs_address, i, 1'b0);
			assign wrCcr  = accWr & isChReg(avs_address, i, 1'b1);
			assign rdCcr  = accRd & isChReg(avs_address, i, 1'b1);
			assign outBitNxt[i] = wrCtl ? ctlNew[CC_OUT] : outBit_r[i];
			// counting either way reaches the value
			assign chMatch[i] = adv_r & ~capMode_r[i] &
				(count_r == ccr_r[i]);

			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					outMode_r[i] <= OM_OUT;
					ie_r[i]      <= 1'b0;
					syncSel_r[i] <= 1'b0;
					capMode_r[i] <= 1'b0;
					inSel_r[i]   <= ISEL_A;
					edgeSel_r[i] <= 2'b00;
					outBit_r[i]  <= 1'b0;
				end
				else
				begin
					outBit_r[i] <= outBitNxt[i];
					if (wrCtl)
					begin
						outMode_r[i] <= tcc_out_mode_t'(ctlNew[CC_OMODE_LSB +: 3]);
						ie_r[i]      <= ctlNew[CC_IE];
						syncSel_r[i] <= ctlNew[CC_SYNC];
						capMode_r[i] <= ctlNew[CC_CAP];
						inSel_r[i]   <= ctlNew[CC_ISEL_LSB +: 2];
						edgeSel_r[i] <= ctlNew[CC_EDGE_LSB +: 2];
					end
				end
			end

			// hardware set wins over a software clear in the same cycle
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					flag_r[i]   <= 1'b0;
					ovr_r[i]    <= 1'b0;
					unread_r[i] <= 1'b0;
				end
				else
				begin
					flag_r[i] <= capEvt[i] | chMatch[i] |
						(wrCtl ? ctlNew[CC_FLAG] : flag_r[i]);
					ovr_r[i]  <= (capEvt[i] & unread_r[i]) |
						(wrCtl ? ctlNew[CC_OVR] : ovr_r[i]);
					if (capEvt[i])
						unread_r[i] <= 1'b1;
					else if (rdCcr)
						unread_r[i] <= 1'b0;
				end
			end

			// no shadow copy: dead time between outputs is software's job
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					ccr_r[i]    <= CCR_RST;
					sLevel_r[i] <= 1'b0;
				end
				else
				begin
					if (capEvt[i])
						ccr_r[i] <= count_r;
					else if (wrCcr)
						ccr_r[i] <= ccrNew[CNT_W-1:0];
					if (chMatch[i])
						sLevel_r[i] <= level[i];
				end
			end

			tcc_capture u_capture
			(
				.clk       (clk),
				.sys_rst   (sys_rst),
				.capInA    (capInA[i]),
				.capInB    (capInB[i]),
				.inSel     (inSel_r[i]),
				.edgeSel   (edgeSel_r[i]),
				.syncSel   (syncSel_r[i]),
				.capEnable (capMode_r[i]),
				.level     (level[i]),
				.capPulse  (capEvt[i])
			);

			tcc_output_unit u_output
			(
				.clk      (clk),
				.sys_rst  (sys_rst),
				.outMode  (outMode_r[i]),
				.chMatch  (chMatch[i]),
				.perMatch (perMatch),
				.swBit    (outBitNxt[i]),
				.timerClr (timerClr),
				.outLevel (chanOut[i])
			);

			chk_capture_copy: assert property (@(posedge clk)
				disable iff (sys_rst)
				capEvt[i] |=> ccr_r[i] == $past(count_r) && flag_r[i])
				else $error("capture did not copy count and set flag");
			chk_overrun_set: assert property (@(posedge clk)
				disable iff (sys_rst)
				(capEvt[i] && unread_r[i]) |=> ovr_r[i])
				else $error("second capture before read left overrun clear");
			chk_match_flag: assert property (@(posedge clk)
				disable iff (sys_rst)
				chMatch[i] |=> flag_r[i] && sLevel_r[i] == $past(level[i]))
				else $error("compare match did not set flag or latch level");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// interrupt requests
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irqCh0_r    <= 1'b0;
			irqShared_r <= 1'b0;
		end
		else
		begin
			irqCh0_r    <= gie_r & flag_r[0] & ie_r[0];
			irqShared_r <= gie_r & ((|(flag_r[NCH-1:1] & ie_r[NCH-1:1])) |
				(wrapFlag_r & wrapIe_r));
		end
	end

	assign irqCh0    = irqCh0_r;
	assign irqShared = irqShared_r;

	////////////////////////////////////////////////////////////////////////
	chk_down_holds: assert property (@(posedge clk) disable iff (sys_rst)
		(cntMode_r == CM_UPDN && dirDown_r && count_r > 16'h0001 &&
		periodLatch_r != '0 && !wrCtrl && !wrCount) |=>
		dirDown_r && count_r == $past(count_r) - 16'h0001)
		else $error("down count left descent before zero");
	chk_up_reaches: assert property (@(posedge clk) disable iff (sys_rst)
		(cntMode_r == CM_UPDN && !dirDown_r && count_r < periodLatch_r &&
		count_r != '0 && !wrCtrl && !wrCount) |=>
		!dirDown_r && count_r == $past(count_r) + 1)
		else $error("up count did not continue to period");
	chk_reverse: assert property (@(posedge clk) disable iff (sys_rst)
		(cntMode_r == CM_UPDN && !dirDown_r && periodLatch_r != '0 &&
		count_r >= periodLatch_r && !wrCtrl && !wrCount) |=> dirDown_r)
		else $error("count above period did not reverse");
	chk_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
		irqCh0 |-> $past(gie_r) && $past(ie_r[0]) && $past(flag_r[0]))
		else $error("channel request without both enables");
	chk_load_nomatch: assert property (@(posedge clk) disable iff (sys_rst)
		wrCount |=> !perMatch && chMatch == '0)
		else $error("match fired after a direct count load");
endmodule

// File: verification/tb_top.sv
// self-checking bench for the capture/compare timer block
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import tcc_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [2:0]  capInA;
	logic [2:0]  capInB;
	logic [2:0]  chanOut;
	logic        irqCh0;
	logic        irqShared;
	logic [31:0] q;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;
	always #4 clk = ~clk;
	tcc_top #(.NCH(3)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .capInA(capInA),
		.capInB(capInB), .chanOut(chanOut), .irqCh0(irqCh0),
		.irqShared(irqShared));
	tcc_pin_model #(.NCH(3)) u_pins (.pinA(capInA), .pinB(capInB),
		.outPin(chanOut));
	////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one access; held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			err_total++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'hf0, 32'h0);
		// software output bit drives the pin at once in mode 0
		bus(1'b1, 8'h18, 32'h4);
		@(negedge clk);
		`CHK(chanOut[1], 1'b1)
		bus(1'b1, 8'h04, 32'h1234);
		bus(1'b1, 8'h24, 32'h55);
		rd(8'h24, 32'h55);
		// software capture: toggle between ground and supply selects
		bus(1'b1, 8'h18, 32'h1d000);
		bus(1'b1, 8'h18, 32'h1f000);
		repeat (4) @(posedge clk);
		rd(8'h18, 32'h1f009);
		rd(8'h1c, 32'h1234);
		bus(1'b1, 8'h18, 32'h1d000);
		repeat (4) @(posedge clk);
		rd(8'h18, 32'h1d001);
		bus(1'b1, 8'h18, 32'h1f800);
		repeat (4) @(posedge clk);
		rd(8'h18, 32'h1f80b);
		// pin capture on rising edge only
		bus(1'b1, 8'h04, 32'h0abc);
		bus(1'b1, 8'h20, 32'h9000);
		u_pins.drive_a(2, 1'b1);
		repeat (8) @(posedge clk);
		rd(8'h20, 32'h9009);
		rd(8'h24, 32'h0abc);
		bus(1'b1, 8'h20, 32'h9000);
		u_pins.drive_a(2, 1'b0);
		repeat (8) @(posedge clk);
		rd(8'h20, 32'h9000);
		// compare run in up mode with requests enabled
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h14, 32'h8);
		bus(1'b1, 8'h10, 32'h100);
		bus(1'b1, 8'h1c, 32'h3);
		bus(1'b1, 8'h18, 32'h160);
		bus(1'b1, 8'h00, 32'h21);
		repeat (30) @(posedge clk);
		bus(1'b1, 8'h00, 32'h20);
		rd(8'h18, 32'h161);
		@(negedge clk);
		`CHK(irqShared, 1'b1)
		`CHK(irqCh0, 1'b1)
		`CHK(chanOut[1], 1'b1)
		bus(1'b1, 8'h18, 32'h60);
		repeat (2) @(negedge clk);
		`CHK(irqShared, 1'b0)
		// up/down with period 4, mode 7 on channel 2, stopped on the way down
		bus(1'b1, 8'h00, 32'h4);
		bus(1'b1, 8'h24, 32'h2);
		bus(1'b1, 8'h20, 32'he0);
		bus(1'b1, 8'h14, 32'h4);
		bus(1'b1, 8'h00, 32'h3);
		repeat (3) @(posedge clk);
		bus(1'b1, 8'h00, 32'h0);
		rd(8'h04, 32'h2);
		`CHK(u_pins.outSeen[2], 1'b1)
		`CHK(chanOut[2], 1'b0)
		give_verdict();
	end
endmodule

// File: verification/tcc_pin_model.sv
// model of the capture pins and output pins around the channels
`timescale 1ns/10ps
module tcc_pin_model
#(
	parameter int NCH = 3
)
(
	output logic [NCH-1:0]      pinA,
	output logic [NCH-1:0]      pinB,
	input  wire logic [NCH-1:0] outPin
);
	logic [NCH-1:0] outSeen = '0;
	// pins change only through drive_a, which the bench calls just after a rising timer clock edge
	initial
	begin
		pinA = '0;
		pinB = '0;
	end
	// remembers every output pin that has been high, read by the bench
	always @(outPin)
		outSeen = outSeen | outPin;
	task automatic drive_a(input int ch, input logic v);
		pinA[ch] <= v;
	endtask
endmodule
